//--- slc_pkg.sv
// Shared constants for the serial line control block.
// Assumes one 10 MHz clock and word-aligned register access.
package slc_pkg;
  localparam int          NUM_PORTS   = 33;
  localparam int          NUM_GROUPS  = 8;
  localparam int          GRP0_PORTS  = 5;
  localparam int          GRP_PORTS   = 4;
  localparam int          STAT_W      = 2;
  localparam int          DSR_OPT_W   = 3;
  localparam int          DTR_OPT_W   = 2;
  localparam int          REG_W       = 16;
  localparam int          ADDR_W      = 12;
  localparam int          IDX_W       = 6;
  // Register kinds within a group, group stride is 16 bytes
  localparam logic [1:0]  KIND_STAT   = 2'h0;
  localparam logic [1:0]  KIND_DSR    = 2'h1;
  localparam logic [1:0]  KIND_DTR    = 2'h2;
  localparam logic [11:0] OFS_STAT_G0 = 12'h000;
  localparam logic [11:0] OFS_DSR_G0  = 12'h004;
  localparam logic [11:0] OFS_DTR_G0  = 12'h008;
  localparam logic [11:0] GRP_STRIDE  = 12'h010;
  // Port communication modes
  localparam logic [1:0]  MODE_MAINT  = 2'h0;
  localparam logic [1:0]  MODE_USER   = 2'h1;
  localparam logic [1:0]  MODE_OTHER  = 2'h2;
  // Option encodings
  localparam logic [2:0]  DSR_NONE    = 3'h0;
  localparam logic [2:0]  DSR_ON_TR   = 3'h1;
  localparam logic [2:0]  DSR_OFF_TR  = 3'h2;
  localparam logic [2:0]  DSR_ON_T    = 3'h3;
  localparam logic [2:0]  DSR_OFF_T   = 3'h4;
  localparam logic [1:0]  DTR_RUN     = 2'h0;
  localparam logic [1:0]  DTR_OFF     = 2'h1;
  localparam logic [1:0]  DTR_RX      = 2'h2;
  // Values after reset, and the AHB NONSEQ transfer code
  localparam logic [2:0]  DSR_OPT_RST = 3'h0;
  localparam logic [1:0]  DTR_OPT_RST = 2'h0;
  localparam logic        RTS_RST     = 1'h1;
  localparam logic        HREADY_RST  = 1'h1;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

  function automatic logic reg_ok(input logic [11:0] a);
    reg_ok = (a[11:7] == 5'h00) && (a[1:0] == 2'h0) && (a[3:2] != 2'h3);
  endfunction
endpackage

//--- slc_reg_if.sv
// Register access path between the bus slave and the line control core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface slc_reg_if;
  logic        wr;
  logic [5:0]  wr_idx;
  logic [15:0] wdata;
  logic [5:0]  rd_idx;
  logic [15:0] rdata;
  modport slave (output wr, output wr_idx, output wdata, output rd_idx, input rdata);
  modport core  (input wr, input wr_idx, input wdata, input rd_idx, output rdata);
endinterface

//--- slc_ahb_slave.sv
// AHB-Lite slave for the line control registers.
// Assumes it is the only slave, so hready_i is its own hreadyout_o.
`timescale 1ns/1ps
module slc_ahb_slave (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [11:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  slc_reg_if.slave         bus
);
  typedef struct packed {
    logic        wpend;
    logic [5:0]  widx;
    logic [31:0] rdata;
    logic        rdy;
  } slc_ahb_st_t;

  slc_ahb_st_t s_q, s_d;
  logic        take;

  assign take        = hsel_i && htrans_i[1] && hready_i;
  assign bus.wr      = s_q.wpend;
  assign bus.wr_idx  = s_q.widx;
  assign bus.wdata   = hwdata_i[15:0];
  assign bus.rd_idx  = haddr_i[7:2];
  assign hrdata_o    = s_q.rdata;
  assign hreadyout_o = s_q.rdy;
  assign hresp_o     = 1'b0;

  always_comb begin
    s_d       = s_q;
    s_d.wpend = 1'b0;
    s_d.rdy   = 1'b1;
    // Writes get one wait state so a following read sees new data
    if (take && hwrite_i) begin
      s_d.wpend = slc_pkg::reg_ok(haddr_i);
      s_d.widx  = haddr_i[7:2];
      s_d.rdy   = 1'b0;
    end
    if (take && !hwrite_i) begin
      s_d.rdata = slc_pkg::reg_ok(haddr_i) ? {16'h0000, bus.rdata} : 32'h00000000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q     <= '0;
      s_q.rdy <= slc_pkg::HREADY_RST;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

//--- slc_line_ctrl.sv
// Line control core for the RS-232 ports, top of the block.
// Assumes dsr_i comes from pins; mode, run and scan inputs share mclk_i.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module slc_line_ctrl #(
  parameter int NP = slc_pkg::NUM_PORTS
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             hsel_i,
  input  wire logic [11:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic      [31:0]      hrdata_o,
  output logic                  hreadyout_o,
  output logic                  hresp_o,
  input  wire logic [NP-1:0]    dsr_i,
  input  wire logic [NP-1:0][1:0] port_mode_i,
  input  wire logic [NP-1:0]    rs485_i,
  input  wire logic             run_i,
  input  wire logic             end_scan_i,
  output logic      [NP-1:0]    dtr_o,
  output logic      [NP-1:0]    tx_en_o,
  output logic      [NP-1:0]    rx_en_o,
  output logic                  request_to_send_output_o
);
  typedef struct packed {
    logic [NP-1:0]      dsr_m;
    logic [NP-1:0]      dsr_s;
    logic [NP-1:0][2:0] dsr_opt;
    logic [NP-1:0][1:0] dtr_opt;
    logic [NP-1:0][1:0] stat;
    logic [NP-1:0]      dtr;
    logic [NP-1:0]      tx;
    logic [NP-1:0]      rx;
    logic               rts;
  } slc_core_st_t;

  slc_core_st_t s_q, s_d;
  slc_reg_if    rbus ();

  slc_ahb_slave u_bus (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hrdata_o    (hrdata_o),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .bus         (rbus.slave)
  );

  // First port of a group and number of ports in it
  function automatic int grp_base(input logic [3:0] g);
    grp_base = (g == 4'h0) ? 0 : slc_pkg::GRP0_PORTS + (int'(g) - 1) * slc_pkg::GRP_PORTS;
  endfunction

  function automatic int grp_cnt(input logic [3:0] g);
    grp_cnt = (g == 4'h0) ? slc_pkg::GRP0_PORTS : slc_pkg::GRP_PORTS;
  endfunction

  assign dtr_o                    = s_q.dtr;
  assign tx_en_o                  = s_q.tx;
  assign rx_en_o                  = s_q.rx;
  assign request_to_send_output_o = s_q.rts;

  // Register read mux
  always_comb begin
    logic [3:0] g;
    logic [1:0] k;
    int         p;
    g          = rbus.rd_idx[5:2];
    k          = rbus.rd_idx[1:0];
    p          = 0;
    rbus.rdata = 16'h0000;
    for (int j = 0; j < slc_pkg::GRP0_PORTS; j++) begin
      p = grp_base(g) + j;
      if (j < grp_cnt(g) && p < NP) begin
        case (k)
          slc_pkg::KIND_STAT: rbus.rdata[2*j +: 2] = s_q.stat[p];
          slc_pkg::KIND_DSR:  rbus.rdata[3*j +: 3] = s_q.dsr_opt[p];
          slc_pkg::KIND_DTR:  rbus.rdata[2*j +: 2] = s_q.dtr_opt[p];
          default:            rbus.rdata = rbus.rdata;
        endcase
      end
    end
  end

  always_comb begin
    logic       user;
    logic       on;
    logic [3:0] g;
    logic [1:0] k;
    int         p;
    s_d   = s_q;
    user  = 1'b0;
    on    = 1'b0;
    g     = rbus.wr_idx[5:2];
    k     = rbus.wr_idx[1:0];
    p     = 0;
    s_d.dsr_m = dsr_i;
    s_d.dsr_s = s_q.dsr_m;
    s_d.rts   = 1'b1;
    for (int i = 0; i < NP; i++) begin
      on   = s_q.dsr_s[i];
      user = (port_mode_i[i] == slc_pkg::MODE_USER);
      if (rs485_i[i]) begin
        s_d.dtr[i] = 1'b0;
        s_d.tx[i]  = !user || run_i;
        s_d.rx[i]  = !user || run_i;
      end else if (port_mode_i[i] == slc_pkg::MODE_MAINT) begin
        s_d.dtr[i] = 1'b1;
        s_d.tx[i]  = 1'b1;
        s_d.rx[i]  = 1'b1;
      end else if (!user) begin
        s_d.dtr[i] = 1'b0;
        s_d.tx[i]  = 1'b1;
        s_d.rx[i]  = 1'b1;
      end else if (!run_i) begin
        s_d.dtr[i] = 1'b0;
        s_d.tx[i]  = 1'b0;
        s_d.rx[i]  = 1'b0;
      end else begin
        case (s_q.dsr_opt[i])
          slc_pkg::DSR_ON_TR: begin
            s_d.tx[i] = on;
            s_d.rx[i] = on;
          end
          slc_pkg::DSR_OFF_TR: begin
            s_d.tx[i] = !on;
            s_d.rx[i] = !on;
          end
          slc_pkg::DSR_ON_T: begin
            s_d.tx[i] = on;
            s_d.rx[i] = 1'b1;
          end
          slc_pkg::DSR_OFF_T: begin
            s_d.tx[i] = !on;
            s_d.rx[i] = 1'b1;
          end
          default: begin
            s_d.tx[i] = 1'b1;
            s_d.rx[i] = 1'b1;
          end
        endcase
        case (s_q.dtr_opt[i])
          slc_pkg::DTR_OFF: s_d.dtr[i] = 1'b0;
          slc_pkg::DTR_RX:  s_d.dtr[i] = s_d.rx[i];
          default:          s_d.dtr[i] = 1'b1;
        endcase
      end
      // Status snapshot, lines on RS485 ports read as off
      if (end_scan_i) begin
        s_d.stat[i] = {s_q.dtr[i], on && !rs485_i[i]};
      end
    end
    // Option writes, one field per port of the addressed group
    if (rbus.wr) begin
      for (int j = 0; j < slc_pkg::GRP0_PORTS; j++) begin
        p = grp_base(g) + j;
        if (j < grp_cnt(g) && p < NP) begin
          if (k == slc_pkg::KIND_DSR) begin
            s_d.dsr_opt[p] = rbus.wdata[3*j +: 3];
          end
          if (k == slc_pkg::KIND_DTR) begin
            s_d.dtr_opt[p] = rbus.wdata[2*j +: 2];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q     <= '0;
      s_q.rts <= slc_pkg::RTS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Checks on port 0, which shares all logic with the others, plus option writes for ports 6 and 33 and bus reads
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence user_run0_s;
    port_mode_i[0] == slc_pkg::MODE_USER && run_i && !rs485_i[0];
  endsequence

  sequence user_stop0_s;
    port_mode_i[0] == slc_pkg::MODE_USER && !run_i && !rs485_i[0];
  endsequence

  rts_held_on_a: assert property (request_to_send_output_o)
    else $error("request to send dropped");

  rs485_no_dtr_a: assert property (rs485_i[0] |=> !dtr_o[0])
    else $error("DTR driven on RS485 port");

  maint_dtr_on_a: assert property (
    port_mode_i[0] == slc_pkg::MODE_MAINT && !rs485_i[0] |=> dtr_o[0] && tx_en_o[0] && rx_en_o[0])
    else $error("maintenance mode gated or dropped DTR");

  other_mode_free_a: assert property (
    port_mode_i[0] >= slc_pkg::MODE_OTHER && !rs485_i[0] |=> !dtr_o[0] && tx_en_o[0] && rx_en_o[0])
    else $error("options applied outside user mode");

  stop_blocks_all_a: assert property (
    user_stop0_s |=> !tx_en_o[0] && !rx_en_o[0] && !dtr_o[0])
    else $error("transfer enabled in stop mode");

  opt_both_on_a: assert property (
    user_run0_s ##0 s_q.dsr_opt[0] == slc_pkg::DSR_ON_TR |=>
      tx_en_o[0] == $past(s_q.dsr_s[0]) && rx_en_o[0] == $past(s_q.dsr_s[0]))
    else $error("option 001 gating wrong");

  opt_both_off_a: assert property (
    user_run0_s ##0 s_q.dsr_opt[0] == slc_pkg::DSR_OFF_TR |=>
      tx_en_o[0] != $past(s_q.dsr_s[0]) && rx_en_o[0] != $past(s_q.dsr_s[0]))
    else $error("option 010 gating wrong");

  opt_tx_on_a: assert property (
    user_run0_s ##0 s_q.dsr_opt[0] == slc_pkg::DSR_ON_T |=>
      tx_en_o[0] == $past(s_q.dsr_s[0]) && rx_en_o[0])
    else $error("option 011 gating wrong");

  opt_tx_off_a: assert property (
    user_run0_s ##0 s_q.dsr_opt[0] == slc_pkg::DSR_OFF_T |=>
      tx_en_o[0] != $past(s_q.dsr_s[0]) && rx_en_o[0])
    else $error("option 100 gating wrong");

  opt_no_gate_a: assert property (
    user_run0_s ##0 (s_q.dsr_opt[0] == slc_pkg::DSR_NONE || s_q.dsr_opt[0] > slc_pkg::DSR_OFF_T) |=>
      tx_en_o[0] && rx_en_o[0])
    else $error("DSR gated with option off");

  dtr_rx_follow_a: assert property (
    user_run0_s ##0 s_q.dtr_opt[0] == slc_pkg::DTR_RX |=> dtr_o[0] == rx_en_o[0])
    else $error("DTR not following receive enable");

  dtr_off_opt_a: assert property (
    user_run0_s ##0 s_q.dtr_opt[0] == slc_pkg::DTR_OFF |=> !dtr_o[0])
    else $error("DTR on with option 01");

  dsr_sync_two_a: assert property (
    $stable(dsr_i[0]) [*3] ##0 (end_scan_i && !rs485_i[0]) |=> s_q.stat[0][0] == $past(dsr_i[0]))
    else $error("DSR status not taken through two stages");

  stat_refresh_a: assert property (
    end_scan_i |=> s_q.stat[0] == {$past(dtr_o[0]), $past(s_q.dsr_s[0]) && !$past(rs485_i[0])})
    else $error("status not refreshed at end of scan");

  stat_hold_a: assert property (!end_scan_i |=> $stable(s_q.stat[0]))
    else $error("status changed between scans");

  wr_dsr_g1_a: assert property (
    rbus.wr && rbus.wr_idx == 6'h05 |=> s_q.dsr_opt[5] == $past(rbus.wdata[2:0]))
    else $error("port 6 option field misplaced");

  sequence wr_taken_s;
    hsel_i && htrans_i[1] && hready_i && hwrite_i;
  endsequence

  sequence rd_taken_s;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  endsequence

  sequence one_wait_s;
    !hreadyout_o ##1 hreadyout_o;
  endsequence

  dtr_run_on_a: assert property (
    user_run0_s ##0 s_q.dtr_opt[0][1] == s_q.dtr_opt[0][0] |=> dtr_o[0])
    else $error("DTR off with option 00 or 11");

  rs485_run_free_a: assert property (
    rs485_i[0] && (port_mode_i[0] != slc_pkg::MODE_USER || run_i) |=> tx_en_o[0] && rx_en_o[0])
    else $error("DSR option applied on RS485 port");

  rs485_stop_off_a: assert property (
    rs485_i[0] && port_mode_i[0] == slc_pkg::MODE_USER && !run_i |=> !tx_en_o[0] && !rx_en_o[0])
    else $error("RS485 port enabled in stop mode");

  rs485_stat_off_a: assert property (rs485_i[0] && end_scan_i |=> !s_q.stat[0][0])
    else $error("DSR status shown on RS485 port");

  wr_dtr_g1_a: assert property (
    rbus.wr && rbus.wr_idx == 6'h06 |=> s_q.dtr_opt[5] == $past(rbus.wdata[1:0]))
    else $error("port 6 DTR option field misplaced");

  wr_dsr_g7_a: assert property (
    rbus.wr && rbus.wr_idx == 6'h1d |=> s_q.dsr_opt[32] == $past(rbus.wdata[11:9]))
    else $error("port 33 option field misplaced");

  stat_wr_ignored_a: assert property (
    rbus.wr && rbus.wr_idx[1:0] == slc_pkg::KIND_STAT |=> $stable(s_q.dsr_opt) && $stable(s_q.dtr_opt))
    else $error("status write changed options");

  opt_hold_a: assert property (!rbus.wr |=> $stable(s_q.dsr_opt) && $stable(s_q.dtr_opt))
    else $error("options changed without a write");

  wr_wait_one_a: assert property (wr_taken_s |=> one_wait_s)
    else $error("write wait state not one cycle");

  rd_stat_g0_a: assert property (
    rd_taken_s ##0 haddr_i == slc_pkg::OFS_STAT_G0 |=> hrdata_o[1:0] == $past(s_q.stat[0]))
    else $error("port 1 status read wrong");

  rd_dsr_g0_a: assert property (
    rd_taken_s ##0 haddr_i == slc_pkg::OFS_DSR_G0 |=> hrdata_o[2:0] == $past(s_q.dsr_opt[0]))
    else $error("port 1 option read wrong");

  rd_unmapped_a: assert property (
    rd_taken_s ##0 !slc_pkg::reg_ok(haddr_i) |=> hrdata_o == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

//--- slc_dev_model.sv
// Far-side RS-232 device model that drives the DSR line of every port.
// Assumes the bench tells it, per port, whether the device is ready or busy.
`timescale 1ns/1ps
module slc_dev_model #(
  parameter int NP = 33
) (
  input  wire logic          mclk_i,
  input  wire logic [NP-1:0] ready_i,
  output logic      [NP-1:0] dsr_o
);
  // DSR on shows ready to accept data or its own sending state
  always_ff @(posedge mclk_i) begin
    dsr_o <= ready_i;
  end
endmodule

//--- tb_serial_line_control_signals.sv
// Self-checking bench for the line control block, register bus and port lines.
// Assumes the single AHB-Lite slave answers with hreadyout tied back to hready.
`timescale 1ns/1ps
module tb_serial_line_control_signals;
  localparam int NP = slc_pkg::NUM_PORTS;
  typedef struct packed {
    logic [1:0] mode; logic run; logic [2:0] dso; logic [1:0] dto; logic dsr; logic [2:0] exp;
  } slc_row_t;
  logic                mclk_i, rst_i, hsel, hwrite, hready, hresp, run, end_scan, rts;
  logic [11:0]         haddr;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         hwdata, hrdata, rd, keep;
  logic [NP-1:0]       dsr, ready, rs485, dtr, tx_en, rx_en;
  logic [NP-1:0][1:0]  mode;
  int                  errors, num_checks;
  // Rows: mode, run, dsr option, dtr option, dsr level, expected {tx, rx, dtr} of port 1
  slc_row_t rows [17] = '{
    '{2'h1,1'h1,3'h0,2'h0,1'h0,3'h7}, '{2'h1,1'h1,3'h1,2'h0,1'h1,3'h7},
    '{2'h1,1'h1,3'h1,2'h2,1'h0,3'h0}, '{2'h1,1'h1,3'h2,2'h2,1'h0,3'h7},
    '{2'h1,1'h1,3'h2,2'h1,1'h1,3'h0}, '{2'h1,1'h1,3'h3,2'h3,1'h0,3'h3},
    '{2'h1,1'h1,3'h3,2'h2,1'h1,3'h7}, '{2'h1,1'h1,3'h4,2'h2,1'h1,3'h3},
    '{2'h1,1'h1,3'h4,2'h1,1'h0,3'h6}, '{2'h1,1'h1,3'h5,2'h0,1'h0,3'h7},
    '{2'h1,1'h1,3'h7,2'h0,1'h1,3'h7}, '{2'h1,1'h0,3'h1,2'h0,1'h1,3'h0},
    '{2'h1,1'h0,3'h0,2'h3,1'h0,3'h0}, '{2'h0,1'h0,3'h1,2'h1,1'h0,3'h7},
    '{2'h0,1'h1,3'h2,2'h1,1'h1,3'h7}, '{2'h2,1'h1,3'h1,2'h0,1'h0,3'h6},
    '{2'h3,1'h1,3'h2,2'h0,1'h1,3'h6}};

  slc_line_ctrl #(.NP(NP)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .dsr_i(dsr), .port_mode_i(mode),
    .rs485_i(rs485), .run_i(run), .end_scan_i(end_scan), .dtr_o(dtr), .tx_en_o(tx_en),
    .rx_en_o(rx_en), .request_to_send_output_o(rts));
  slc_dev_model #(.NP(NP)) dev_u (.mclk_i(mclk_i), .ready_i(ready), .dsr_o(dsr));

  initial begin
    mclk_i = 1'h0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'h1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge mclk_i); while (hready !== 1'h1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge mclk_i); while (hready !== 1'h1);
    r = hrdata;
  endtask

  task automatic scan();
    end_scan <= 1'h1;
    @(posedge mclk_i);
    end_scan <= 1'h0;
    @(posedge mclk_i);
  endtask

  task automatic settle();
    repeat (5) @(posedge mclk_i);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    results();
  end

  initial begin
    errors = 0; num_checks = 0;
    rst_i = 1'h1; hsel = 1'h0; haddr = 12'h000; htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2;
    hwdata = 32'h0; run = 1'h0; end_scan = 1'h0; ready = '0; rs485 = '0; mode = '0;
    repeat (8) @(posedge mclk_i);
    chk({31'h0, rts}, 32'h1);
    rst_i <= 1'h0;
    @(posedge mclk_i);
    bus(1'h0, 12'h004, 32'h0, rd);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'h1, 12'h004, {29'h0, rows[i].dso}, rd);
      bus(1'h1, 12'h008, {30'h0, rows[i].dto}, rd);
      mode <= {NP{rows[i].mode}}; run <= rows[i].run; ready <= {NP{rows[i].dsr}};
      settle();
      chk({29'h0, tx_en[0], rx_en[0], dtr[0]}, {29'h0, rows[i].exp});
      scan();
      bus(1'h0, 12'h000, 32'h0, rd);
      chk(rd & 32'h3, {30'h0, rows[i].exp[0], rows[i].dsr});
      bus(1'h0, 12'h004, 32'h0, rd);
      chk(rd, {29'h0, rows[i].dso});
      $display("row %0d done", i);
    end
    // Group words beyond the first group and field packing
    bus(1'h1, 12'h074, 32'h200, rd);
    bus(1'h1, 12'h018, 32'h1, rd);
    bus(1'h1, 12'h014, 32'h3, rd);
    mode <= {NP{2'h1}}; run <= 1'h1; ready <= '0;
    settle();
    chk({27'h0, tx_en[5], tx_en[32], tx_en[29], dtr[5], dtr[6]}, 32'h5);
    bus(1'h0, 12'h074, 32'h0, rd);
    chk(rd, 32'h200);
    $display("packing test done");
    // Status holds between scans and ignores writes
    scan();
    bus(1'h0, 12'h070, 32'h0, keep);
    chk(keep & 32'hc3, 32'h82);
    ready <= '1;
    settle();
    bus(1'h1, 12'h070, 32'hffff, rd);
    bus(1'h0, 12'h070, 32'h0, rd);
    chk(rd, keep);
    scan();
    bus(1'h0, 12'h070, 32'h0, rd);
    chk(rd & 32'hc3, 32'hc3);
    $display("status test done");
    bus(1'h0, 12'h00c, 32'h0, rd);
    chk(rd, 32'h0);
    bus(1'h0, 12'h080, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("unmapped test done");
    // RS485 ports get no line control
    rs485 <= '1; ready <= '1;
    settle();
    chk({30'h0, tx_en[0], dtr[0]}, 32'h2);
    scan();
    bus(1'h0, 12'h000, 32'h0, rd);
    chk(rd & 32'h3, 32'h0);
    run <= 1'h0;
    settle();
    chk({30'h0, tx_en[0], rx_en[0]}, 32'h0);
    chk({31'h0, rts}, 32'h1);
    $display("rs485 test done");
    // Reset in mid-run clears options and keeps request to send on
    rst_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    chk({29'h0, tx_en[0], dtr[0], rts}, 32'h1);
    rst_i <= 1'h0;
    @(posedge mclk_i);
    bus(1'h0, 12'h074, 32'h0, rd);
    chk(rd, 32'h0);
    $display("mid-run reset test done");
    results();
  end
endmodule
